// file: core/aacc_core.sv
// apb-reached execution datapath for add/and accumulator instructions
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "aacc_defs.svh"
module aacc_core (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output aacc_pkg::aacc_byte_t   acc_out,
    output logic                   carry_flag,
    output logic                   digit_carry_flag,
    output logic                   zero_flag,
    output logic                   file_we,
    output logic [6:0]             file_addr,
    output aacc_pkg::aacc_byte_t   file_wdata
);
    import aacc_pkg::*;

    logic        rst_s1_q;
    logic        rst_s2_q;
    aacc_byte_t  acc_q;
    aacc_byte_t  file_q;
    logic [13:0] instr_q;
    aacc_op_e    op_q;
    aacc_op_e    op_d;
    aacc_phase_e phase_q;
    logic        busy_q;
    logic        c_q;
    logic        dcy_q;
    logic        z_q;
    logic        fwe_q;
    logic [6:0]  faddr_q;
    aacc_byte_t  fwdata_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        err_q;
    logic        wr_acc;
    logic        access;
    logic        wr_done;
    logic        mapped;

    aacc_alu_if alu_bus ();

    aacc_alu u_alu (
        .bus (alu_bus)
    );

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign access = psel && penable && !ready_q;
    // writes commit at the edge where pready is seen, as the master expects
    assign wr_done = psel && penable && pwrite && ready_q;
    assign mapped = (paddr == `AACC_REG_INSTR) || (paddr == `AACC_REG_ACC) ||
                    (paddr == `AACC_REG_STATUS) || (paddr == `AACC_REG_FWR) ||
                    (paddr == `AACC_REG_FRD);

    // opcode decode; unrecognised words are ignored
    always_comb begin
        op_d = AACC_OP_NONE;
        if (pwdata[13:9] == `AACC_ADD_LIT_TOP) begin
            op_d = AACC_OP_ADDL;
        end else if (pwdata[13:8] == `AACC_AND_LIT_TOP) begin
            op_d = AACC_OP_ANDL;
        end else if (pwdata[13:8] == `AACC_ADD_FILE_TOP) begin
            op_d = AACC_OP_ADDF;
        end else if (pwdata[13:8] == `AACC_AND_FILE_TOP) begin
            op_d = AACC_OP_ANDF;
        end
    end

    // operand selection: literal or the file register snapshot
    // the literal path never looks at the file snapshot
    always_comb begin
        alu_bus.op   = op_q;
        alu_bus.acc  = acc_q;
        if ((op_q == AACC_OP_ADDL) || (op_q == AACC_OP_ANDL)) begin
            alu_bus.opnd = instr_q[`AACC_LIT_MSB:0];
        end else begin
            alu_bus.opnd = file_q;
        end
    end

    // instruction launch; writes to the instruction register while busy are dropped
    // op_d reads pwdata, which the master holds through the commit edge
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            instr_q <= 14'h0000;
            op_q    <= AACC_OP_NONE;
        end else if (wr_done && paddr == `AACC_REG_INSTR && !busy_q) begin
            instr_q <= pwdata[13:0];
            op_q    <= op_d;
        end else if (busy_q && phase_q == AACC_Q4) begin
            op_q    <= AACC_OP_NONE;
        end
    end

    // four-phase instruction cycle, one oscillator period per clock
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            phase_q <= AACC_Q1;
            busy_q  <= 1'b0;
        end else if (!busy_q) begin
            phase_q <= AACC_Q1;
            // decoded words only; undecoded writes leave the block idle
            busy_q  <= wr_done && paddr == `AACC_REG_INSTR && op_d != AACC_OP_NONE;
        end else begin
            case (phase_q)
                AACC_Q1: phase_q <= AACC_Q2;
                AACC_Q2: phase_q <= AACC_Q3;
                AACC_Q3: phase_q <= AACC_Q4;
                AACC_Q4: begin
                    phase_q <= AACC_Q1;
                    busy_q  <= 1'b0;
                end
                default: phase_q <= AACC_Q1;
            endcase
        end
    end

    // result lands at the end of Q4
    assign wr_acc = busy_q && phase_q == AACC_Q4 &&
                    ((op_q == AACC_OP_ADDL) || (op_q == AACC_OP_ANDL) ||
                     !instr_q[`AACC_DEST_BIT]);

    // accumulator: apb load, or instruction result
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            acc_q <= `AACC_ACC_RST;
        end else if (wr_acc) begin
            acc_q <= alu_bus.res;
        end else if (wr_done && paddr == `AACC_REG_ACC && !busy_q) begin
            acc_q <= pwdata[7:0];
        end
    end

    // file register operand, held by software or written back by the datapath
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            file_q <= 8'h00;
        end else if (busy_q && phase_q == AACC_Q4 && op_q inside {AACC_OP_ADDF, AACC_OP_ANDF}
                     && instr_q[`AACC_DEST_BIT]) begin
            file_q <= alu_bus.res;
        end else if (wr_done && paddr == `AACC_REG_FWR && !busy_q) begin
            file_q <= pwdata[7:0];
        end
    end

    // file write-back strobe toward the register file, one clock wide
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            fwe_q    <= 1'b0;
            faddr_q  <= 7'h00;
            fwdata_q <= 8'h00;
        end else begin
            fwe_q    <= busy_q && phase_q == AACC_Q4 &&
                        op_q inside {AACC_OP_ADDF, AACC_OP_ANDF} &&
                        instr_q[`AACC_DEST_BIT];
            // address and data track every clock; only the strobe qualifies them
            faddr_q  <= instr_q[`AACC_ADDR_MSB:0];
            fwdata_q <= alu_bus.res;
        end
    end

    // flags: add updates all three, and updates zero only
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            c_q   <= `AACC_FLAG_RST;
            dcy_q <= `AACC_FLAG_RST;
            z_q  <= `AACC_FLAG_RST;
        end else if (busy_q && phase_q == AACC_Q4 && op_q != AACC_OP_NONE) begin
            z_q <= alu_bus.zero;
            if (op_q == AACC_OP_ADDL || op_q == AACC_OP_ADDF) begin
                c_q  <= alu_bus.carry;
                dcy_q <= alu_bus.dcarry;
            end
        end
    end

    // apb slave, one wait state, unmapped addresses answer with an error
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= access;
            err_q   <= access && !mapped;
            rdata_q <= 32'h0000_0000;
            // read data is captured on the first access cycle and stands with pready
            if (access && !pwrite) begin
                case (paddr)
                    `AACC_REG_INSTR:  rdata_q <= {18'h00000, instr_q};
                    `AACC_REG_ACC:    rdata_q <= {24'h000000, acc_q};
                    `AACC_REG_STATUS: rdata_q <= {28'h0000000, busy_q, z_q, dcy_q, c_q};
                    `AACC_REG_FWR:    rdata_q <= {24'h000000, file_q};
                    `AACC_REG_FRD:    rdata_q <= {24'h000000, file_q};
                    default:          rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata           = rdata_q;
    assign pready           = ready_q;
    assign pslverr          = err_q;
    assign acc_out          = acc_q;
    assign carry_flag       = c_q;
    assign digit_carry_flag = dcy_q;
    assign zero_flag        = z_q;
    assign file_we          = fwe_q;
    assign file_addr        = faddr_q;
    assign file_wdata       = fwdata_q;

    // instruction finishes four clocks after launch
    a_cycle_len: assert property (@(posedge clk) disable iff (!rst_s2_q)
        $rose(busy_q) |-> busy_q [*4] ##1 !busy_q)
        else $error("instruction cycle not four clocks");
    a_and_lit: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ANDL) |=>
        acc_q == ($past(acc_q) & $past(instr_q[7:0])))
        else $error("and literal result wrong");
    a_add_lit: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ADDL) |=>
        {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(instr_q[7:0])})
        else $error("add literal result wrong");
    a_add_file: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ADDF && !instr_q[7]) |=>
        acc_q == 8'($past(acc_q) + $past(file_q)))
        else $error("add file result wrong");
    a_and_file: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ANDF && instr_q[7]) |=>
        file_q == ($past(acc_q) & $past(file_q)))
        else $error("and file result wrong");
    a_dest_keep: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q inside {AACC_OP_ADDF, AACC_OP_ANDF}
         && instr_q[7]) |=> $stable(acc_q) && file_we)
        else $error("destination steering wrong");
    a_flag_zero: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q != AACC_OP_NONE && !instr_q[7]) |=>
        z_q == (acc_q == 8'h00))
        else $error("zero flag wrong");
    a_and_flags: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q inside {AACC_OP_ANDL, AACC_OP_ANDF}) |=>
        $stable(c_q) && $stable(dcy_q))
        else $error("and changed carry flags");

    // steering and carries on the paths the checks above leave open
    a_file_keep: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q != AACC_OP_NONE &&
         !(op_q inside {AACC_OP_ADDF, AACC_OP_ANDF} && instr_q[7])) |=>
        $stable(file_q) && !file_we)
        else $error("file register touched on accumulator destination");
    a_add_back: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ADDF && instr_q[7]) |=>
        file_q == 8'($past(acc_q) + $past(file_q)))
        else $error("add file write-back wrong");
    a_and_acc: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ANDF && !instr_q[7]) |=>
        acc_q == ($past(acc_q) & $past(file_q)))
        else $error("and file accumulator result wrong");
    a_lit_dcarry: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ADDL) |=>
        dcy_q == ((5'($past(acc_q[3:0])) + 5'($past(instr_q[3:0]))) >= 5'h10))
        else $error("add literal digit carry wrong");
    a_file_carry: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q == AACC_OP_ADDF) |=>
        c_q == ((9'($past(acc_q)) + 9'($past(file_q))) >= 9'h100) &&
        dcy_q == ((5'($past(acc_q[3:0])) + 5'($past(file_q[3:0]))) >= 5'h10))
        else $error("add file carries wrong");
    a_zero_file: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && phase_q == AACC_Q4 && op_q inside {AACC_OP_ADDF, AACC_OP_ANDF}
         && instr_q[7]) |=> z_q == (file_q == 8'h00))
        else $error("zero flag wrong on file destination");

    // sequencing and bus refusal
    a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_s2_q)
        (busy_q && wr_done && paddr == `AACC_REG_ACC && !wr_acc) |=> $stable(acc_q))
        else $error("accumulator written while busy");
    a_idle_phase: assert property (@(posedge clk) disable iff (!rst_s2_q)
        !busy_q |-> phase_q == AACC_Q1)
        else $error("phase not at Q1 while idle");
    a_launch_src: assert property (@(posedge clk) disable iff (!rst_s2_q)
        $rose(busy_q) |-> $past(wr_done) && $past(paddr) == `AACC_REG_INSTR)
        else $error("instruction started without a committed write");
    a_we_pulse: assert property (@(posedge clk) disable iff (!rst_s2_q)
        file_we |=> !file_we)
        else $error("write-back strobe longer than one clock");
endmodule // aacc_core

// file: shared/aacc_defs.svh
// constants for the accumulator add/and execution block
`ifndef AACC_DEFS_SVH
`define AACC_DEFS_SVH

// opcode fields: add literal bits 13:9, the others bits 13:8
`define AACC_ADD_LIT_TOP  5'h1F
`define AACC_AND_LIT_TOP  6'h39
`define AACC_ADD_FILE_TOP 6'h07
`define AACC_AND_FILE_TOP 6'h05
// instruction field positions
`define AACC_DEST_BIT    7
`define AACC_ADDR_MSB    6
`define AACC_LIT_MSB     7
// oscillator periods per instruction cycle
`define AACC_OSC_PER_CYC 4
// reset values
`define AACC_ACC_RST     8'h00
`define AACC_FLAG_RST    1'b0
// apb register byte offsets
`define AACC_REG_INSTR   12'h000
`define AACC_REG_ACC     12'h004
`define AACC_REG_STATUS  12'h008
`define AACC_REG_FWR     12'h00C
`define AACC_REG_FRD     12'h010
// status field positions
`define AACC_ST_C        0
`define AACC_ST_DCY      1
`define AACC_ST_Z        2
`define AACC_ST_BUSY     3

`endif

// file: shared/aacc_pkg.sv
// types for the accumulator add/and execution block
package aacc_pkg;
    typedef enum logic [2:0] {
        AACC_OP_NONE = 3'h0,
        AACC_OP_ADDL = 3'h1,
        AACC_OP_ANDL = 3'h2,
        AACC_OP_ADDF = 3'h3,
        AACC_OP_ANDF = 3'h4
    } aacc_op_e;
    typedef enum logic [1:0] {
        AACC_Q1 = 2'h0,
        AACC_Q2 = 2'h1,
        AACC_Q3 = 2'h2,
        AACC_Q4 = 2'h3
    } aacc_phase_e;
    typedef logic [7:0] aacc_byte_t;
endpackage

// file: shared/aacc_alu_if.sv
// carrier between the sequencer and the arithmetic unit
`timescale 1ns/100ps
interface aacc_alu_if;
    import aacc_pkg::*;
    aacc_op_e   op;
    aacc_byte_t acc;
    aacc_byte_t opnd;
    aacc_byte_t res;
    logic       carry;
    logic       dcarry;
    logic       zero;
    modport seq (output op, output acc, output opnd, input res, input carry, input dcarry,
                 input zero);
    modport alu (input op, input acc, input opnd, output res, output carry, output dcarry,
                 output zero);
endinterface

// file: core/aacc_alu.sv
// combinational add/and unit with flag generation
`timescale 1ns/100ps
`include "aacc_defs.svh"
module aacc_alu (
    aacc_alu_if.alu bus
);
    import aacc_pkg::*;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic       is_add;

    // split add keeps the nibble carry visible
    always_comb begin
        is_add     = (bus.op == AACC_OP_ADDL) || (bus.op == AACC_OP_ADDF);
        lo_sum     = {1'b0, bus.acc[3:0]} + {1'b0, bus.opnd[3:0]};
        hi_sum     = {1'b0, bus.acc[7:4]} + {1'b0, bus.opnd[7:4]} + {4'h0, lo_sum[4]};
        if (is_add) begin
            bus.res    = {hi_sum[3:0], lo_sum[3:0]};
        end else begin
            bus.res    = bus.acc & bus.opnd;
        end
        bus.carry  = hi_sum[4];
        bus.dcarry = lo_sum[4];
        bus.zero   = (bus.res == 8'h00);
    end
endmodule // aacc_alu

// file: tb/aacc_core_bench.sv
// self-checking bench for the add/and accumulator execution block
`timescale 1ns/100ps
`include "aacc_defs.svh"
module aacc_core_bench;
    import aacc_pkg::*;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    aacc_byte_t  acc_out;
    logic        carry_flag;
    logic        digit_carry_flag;
    logic        zero_flag;
    logic        file_we;
    logic [6:0]  file_addr;
    aacc_byte_t  file_wdata;
    int          n_errors;
    int          n_tests;
    int          we_n;
    logic [6:0]  we_a;
    aacc_byte_t  we_d;
    logic        ec;
    logic        edc;
    logic [13:0] t_ins [9] = '{14'h3E15, 14'h3F01, 14'h395F, 14'h3900, 14'h077F,
                               14'h0785, 14'h05A3, 14'h0512, 14'h0740};
    aacc_byte_t  t_w [9]   = '{8'h10, 8'hFF, 8'hA3, 8'hA3, 8'h17, 8'h08, 8'h17, 8'h0F, 8'h80};
    aacc_byte_t  t_f [9]   = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC2, 8'h08, 8'hC2, 8'hF0, 8'h80};
    int          t_mode [9] = '{1, 2, 0, 0, 2, 0, 2, 0, 0};

    aacc_core dut_u (
        .clk              (clk),
        .reset_n          (reset_n),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .acc_out          (acc_out),
        .carry_flag       (carry_flag),
        .digit_carry_flag (digit_carry_flag),
        .zero_flag        (zero_flag),
        .file_we          (file_we),
        .file_addr        (file_addr),
        .file_wdata       (file_wdata)
    );

    // free-running clock, 20 ns period
    always #10 clk = ~clk;

    // write-back pulses are caught here since register polling can miss them
    always @(posedge clk) begin
        if (file_we === 1'b1) begin
            we_n++;
            we_a = file_addr;
            we_d = file_wdata;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            check(32'h0, 32'h1, "no pready");
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic e;
        apb(a, 1'b0, 32'h0, v, e);
    endtask

    // mode 1 times the update, mode 2 pokes ACC while busy (must be ignored)
    task automatic run(input logic [13:0] ins, input aacc_byte_t w0, input aacc_byte_t f0,
                       input int mode);
        logic [31:0] v;
        logic [8:0]  sum;
        logic [4:0]  nib;
        aacc_byte_t  op2;
        aacc_byte_t  res;
        logic        add;
        logic        lit;
        logic        d;
        int          n;
        int          we0;
        lit = (ins[13:12] == 2'b11);
        add = (ins[13:9] == 5'h1F) || (ins[13:8] == 6'h07);
        op2 = lit ? ins[7:0] : f0;
        sum = {1'b0, w0} + {1'b0, op2};
        nib = {1'b0, w0[3:0]} + {1'b0, op2[3:0]};
        res = add ? sum[7:0] : (w0 & op2);
        if (add) begin
            ec = sum[8];
            edc = nib[4];
        end
        d = !lit && ins[`AACC_DEST_BIT];
        we0 = we_n;
        wr(`AACC_REG_FWR, 32'(f0));
        wr(`AACC_REG_ACC, 32'(w0));
        wr(`AACC_REG_INSTR, 32'(ins));
        // look mid-cycle so the update edge itself is never raced
        if (mode == 1) begin
            repeat (3) @(posedge clk);
            @(negedge clk);
            check(32'(acc_out), 32'(w0), "acc early");
            @(posedge clk);
            @(negedge clk);
            check(32'(acc_out), 32'(res), "acc late");
        end
        if (mode == 2) begin
            wr(`AACC_REG_ACC, 32'h0000_005A);
        end
        n = 0;
        do begin
            rd(`AACC_REG_STATUS, v);
            n++;
        end while (v[`AACC_ST_BUSY] !== 1'b0 && n < 20);
        check(32'(v[`AACC_ST_BUSY]), 32'h0, "busy cleared");
        rd(`AACC_REG_ACC, v);
        check(v, 32'(d ? w0 : res), "acc reg");
        check(32'(acc_out), 32'(d ? w0 : res), "acc port");
        rd(`AACC_REG_FRD, v);
        check(v, 32'(d ? res : f0), "file reg");
        check(32'(we_n - we0), 32'(d), "write-back count");
        if (d) begin
            check(32'({we_a, we_d}), 32'({ins[6:0], res}), "write-back");
        end
        rd(`AACC_REG_STATUS, v);
        check(v[3:0], {1'b0, res == 8'h00, edc, ec}, "status");
        check(32'({zero_flag, digit_carry_flag, carry_flag}),
              32'({res == 8'h00, edc, ec}), "flag ports");
    endtask

    // overall hang guard, far above the run length
    initial begin
        repeat (20000) @(posedge clk);
        check(32'h0, 32'h1, "watchdog");
        final_report();
    end

    initial begin
        logic [31:0] v;
        logic        e;
        clk = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        n_tests = 0;
        we_n = 0;
        ec = 1'b0;
        edc = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`AACC_REG_STATUS, v);
        check(v, 32'h0, "status reset");
        apb(12'h014, 1'b0, 32'h0, v, e);
        check(32'(e), 32'h1, "unmapped error");
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            run(t_ins[i], t_w[i], t_f[i], t_mode[i]);
            $display("test op %0d done", i);
        end
        // undecoded word leaves the accumulator alone and never goes busy
        wr(`AACC_REG_ACC, 32'h0000_0042);
        wr(`AACC_REG_INSTR, 32'h0000_0000);
        rd(`AACC_REG_STATUS, v);
        check(32'(v[`AACC_ST_BUSY]), 32'h0, "nop busy");
        check(32'(acc_out), 32'h0000_0042, "nop acc");
        check(32'(zero_flag), 32'h1, "nop flags");
        $display("test undecoded done");
        final_report();
    end
endmodule // aacc_core_bench
